// [verilog/psram_pkg.sv]
// package of shared constants and types for the pipelined sync sram pair
package psram_pkg;
  localparam int PSRAM_LANE_BITS = 9;
  localparam int PSRAM_CLK_NS = 25;
  localparam int PSRAM_POWERUP_NS = 4000;
  localparam int PSRAM_RECOVER_NS = 200;
  localparam int PSRAM_POWERUP_CYC = (PSRAM_POWERUP_NS + PSRAM_CLK_NS - 1) / PSRAM_CLK_NS;
  localparam int PSRAM_RECOVER_CYC = (PSRAM_RECOVER_NS + PSRAM_CLK_NS - 1) / PSRAM_CLK_NS;
  localparam int PSRAM_CNT_W = 8;
  localparam logic [1:0] PSRAM_STRAP_VAL = 2'h2;
  typedef enum logic [1:0]
  {
    PSRAM_ST_POWERUP = 2'b00,
    PSRAM_ST_IDLE = 2'b01,
    PSRAM_ST_SLEEP = 2'b10,
    PSRAM_ST_RECOVER = 2'b11
  } psram_state_t;
endpackage : psram_pkg

// [verilog/psram_if.sv]
// interface carrying the synchronous sram bus between controller and memory
`timescale 1ns/1ps
interface psram_if #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17
);
  logic [ADDR_W-1:0] word_addr;
  logic select_n;
  logic global_write_n;
  logic [DATA_W/9-1:0] lane_write_n;
  logic output_enable_n;
  logic sleep_request;
  logic [1:0] protocol_strap_pins;
  logic [DATA_W-1:0] ctl_data_out;
  logic ctl_data_oe;
  logic [DATA_W-1:0] mem_data_out;
  logic mem_data_oe;
  logic [DATA_W-1:0] byte_lane_data;
  assign byte_lane_data = mem_data_oe ? mem_data_out : ctl_data_out;
  modport mem
  (
    input word_addr, select_n, global_write_n, lane_write_n, output_enable_n,
    input sleep_request, protocol_strap_pins, ctl_data_out, ctl_data_oe,
    input byte_lane_data,
    output mem_data_out, mem_data_oe
  );
  modport ctl
  (
    output word_addr, select_n, global_write_n, lane_write_n, output_enable_n,
    output sleep_request, protocol_strap_pins, ctl_data_out, ctl_data_oe,
    input mem_data_out, mem_data_oe, byte_lane_data
  );
endinterface : psram_if

// [verilog/psram_mem.sv]
// memory end: pipelined synchronous sram with byte lanes and sleep
`timescale 1ns/1ps
module psram_mem
  import psram_pkg::*;
#(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17
)
(
  input wire logic clk_sys, // sram clock
  psram_if.mem bus, // sram pins
  output logic asleep // high while in low-power state
);
  localparam int LANES = DATA_W / PSRAM_LANE_BITS;
  // 128K x 36 by default, 256K x 18 with DATA_W 18 and ADDR_W 18
  logic [DATA_W-1:0] mem_array [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] addr_ff;
  logic sel_n_ff;
  logic gw_n_ff;
  logic [LANES-1:0] lw_n_ff;
  logic [DATA_W-1:0] din_ff;
  logic [DATA_W-1:0] dout_ff;
  logic read_ff;
  logic sleep_s1_ff;
  logic sleep_s2_ff;
  logic sleep_now;
  // sleep acts asynchronously on the outputs, synchronised for the core
  assign sleep_now = bus.sleep_request;
  assign asleep = bus.sleep_request;
  always_ff @(posedge clk_sys)
  begin
    sleep_s1_ff <= bus.sleep_request;
    sleep_s2_ff <= sleep_s1_ff;
  end
  // input registers; captured values are ignored while asleep
  always_ff @(posedge clk_sys)
  begin
    addr_ff <= bus.word_addr;
    sel_n_ff <= bus.select_n | sleep_s2_ff | sleep_now;
    gw_n_ff <= bus.global_write_n;
    lw_n_ff <= bus.lane_write_n;
    din_ff <= bus.byte_lane_data;
  end
  // self-timed array write one cycle after capture
  always_ff @(posedge clk_sys)
  begin
    if (!sel_n_ff && !gw_n_ff)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (!lw_n_ff[i])
        begin
          mem_array[addr_ff][i*PSRAM_LANE_BITS +: PSRAM_LANE_BITS] <=
            din_ff[i*PSRAM_LANE_BITS +: PSRAM_LANE_BITS];
        end
      end
    end
  end
  // output register: read launched on the edge after capture
  always_ff @(posedge clk_sys)
  begin
    read_ff <= !sel_n_ff && gw_n_ff && !sleep_s2_ff;
    if (!sel_n_ff && gw_n_ff)
    begin
      dout_ff <= mem_array[addr_ff];
    end
  end
  // sense data is not kept over sleep: stale reads are blocked on wake
  assign bus.mem_data_out = dout_ff;
  assign bus.mem_data_oe = read_ff && !bus.output_enable_n && !sleep_now;
endmodule : psram_mem

// [verilog/psram_ctl.sv]
// controller end: drives the sram bus from simple user requests
`timescale 1ns/1ps
module psram_ctl
  import psram_pkg::*;
#(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17,
  parameter int POWERUP_CYC = PSRAM_POWERUP_CYC
)
(
  input wire logic clk_sys, // controller clock, also the sram clock
  input wire logic rst_n, // asynchronous reset, active low
  psram_if.ctl bus, // sram pins
  input wire logic req_valid, // access request
  output logic req_ready, // request taken this cycle
  input wire logic req_write, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] req_addr, // word address
  input wire logic [DATA_W/9-1:0] req_lanes, // lanes to write, active high
  input wire logic [DATA_W-1:0] req_wdata, // write data
  input wire logic sleep_req, // ask for low-power state
  output logic sleeping, // sram is asleep
  output logic rd_valid, // read data valid pulse
  output logic [DATA_W-1:0] rd_data // read data
);
  localparam int LANES = DATA_W / PSRAM_LANE_BITS;
  psram_state_t state_ff;
  psram_state_t nxt_state;
  logic [PSRAM_CNT_W-1:0] cnt_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic sel_n_ff;
  logic gw_n_ff;
  logic [LANES-1:0] lw_n_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic wr_oe_ff;
  logic [2:0] rd_pipe_ff;
  logic sleep_ff;
  logic wr_tail_ff;
  logic idle_bus;
  // a write must also have been captured before sleep may start
  assign idle_bus = sel_n_ff && (rd_pipe_ff == 3'h0) && !wr_tail_ff;
  // a write two cycles behind a read would meet the read data on the bus
  assign req_ready = (state_ff == PSRAM_ST_IDLE) && !sleep_req && !(req_write && rd_pipe_ff[0]);
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      PSRAM_ST_POWERUP: if (cnt_ff == '0) nxt_state = PSRAM_ST_IDLE;
      PSRAM_ST_IDLE: if (sleep_req && idle_bus) nxt_state = PSRAM_ST_SLEEP;
      PSRAM_ST_SLEEP: if (!sleep_req) nxt_state = PSRAM_ST_RECOVER;
      PSRAM_ST_RECOVER: if (cnt_ff == '0) nxt_state = PSRAM_ST_IDLE;
      default: nxt_state = PSRAM_ST_POWERUP;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= PSRAM_ST_POWERUP;
    else
      state_ff <= nxt_state;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= PSRAM_CNT_W'(POWERUP_CYC - 1);
    else if (state_ff == PSRAM_ST_SLEEP)
      cnt_ff <= PSRAM_CNT_W'(PSRAM_RECOVER_CYC - 1);
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - PSRAM_CNT_W'(1);
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sleep_ff <= 1'b0;
    else
      sleep_ff <= (nxt_state == PSRAM_ST_SLEEP);
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wr_tail_ff <= 1'b0;
    else
      wr_tail_ff <= wr_oe_ff;
  end
  // bus drive: address, controls and data launched together
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_ff <= '0;
      sel_n_ff <= 1'b1;
      gw_n_ff <= 1'b1;
      lw_n_ff <= '1;
      wdata_ff <= '0;
      wr_oe_ff <= 1'b0;
    end
    else
    begin
      sel_n_ff <= !(req_valid && req_ready);
      wr_oe_ff <= req_valid && req_ready && req_write;
      if (req_valid && req_ready)
      begin
        addr_ff <= req_addr;
        gw_n_ff <= !req_write;
        lw_n_ff <= ~req_lanes;
        wdata_ff <= req_wdata;
      end
    end
  end
  // read returns two edges after launch: capture edge then output edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rd_pipe_ff <= 3'h0;
    else
      rd_pipe_ff <= {rd_pipe_ff[1:0], !sel_n_ff && gw_n_ff};
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= '0;
    else if (rd_pipe_ff[1])
      rd_data <= bus.byte_lane_data;
  end
  assign rd_valid = rd_pipe_ff[2];
  assign sleeping = sleep_ff;
  assign bus.word_addr = addr_ff;
  assign bus.select_n = sel_n_ff;
  assign bus.global_write_n = gw_n_ff;
  assign bus.lane_write_n = lw_n_ff;
  assign bus.output_enable_n = 1'b0;
  assign bus.sleep_request = sleep_ff;
  assign bus.protocol_strap_pins = PSRAM_STRAP_VAL;
  assign bus.ctl_data_out = wdata_ff;
  assign bus.ctl_data_oe = wr_oe_ff;
endmodule : psram_ctl

// [verification/psram_sva.sv]
// assertions on the sram bus between controller and memory
`timescale 1ns/1ps
module psram_sva
(
  input wire logic clk_sys, // bus clock
  input wire logic rst_n, // reset, active low
  input wire logic select_n, // select, active low
  input wire logic global_write_n, // global write, active low
  input wire logic sleep_request, // sleep level
  input wire logic [1:0] protocol_strap_pins, // mode straps
  input wire logic ctl_data_oe, // controller drives data
  input wire logic mem_data_oe // memory drives data
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd;
    !select_n && global_write_n && !sleep_request;
  endsequence
  sequence s_wr;
    !select_n && !global_write_n && !sleep_request;
  endsequence
  property p_rd_data;
    s_rd |-> ##2 mem_data_oe;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not driven");
  property p_wr_data;
    s_wr |-> ctl_data_oe;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data missing");
  property p_wr_float;
    s_wr |-> ##2 !mem_data_oe;
  endproperty
  a_wr_float: assert property (p_wr_float) else $error("memory drove after write");
  property p_desel_float;
    select_n && !sleep_request |-> ##2 !mem_data_oe;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("drove when idle");
  property p_sleep_float;
    sleep_request |-> !mem_data_oe;
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("drove in sleep");
  property p_sleep_idle;
    $rose(sleep_request) |-> select_n && $past(select_n) && $past(select_n, 2);
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep with access");
  property p_wake_hold;
    $fell(sleep_request) |-> select_n [*8];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("access too soon");
  property p_strap;
    protocol_strap_pins == 2'h2;
  endproperty
  a_strap: assert property (p_strap) else $error("strap pins wrong");
  property p_no_clash;
    !(ctl_data_oe && mem_data_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
endmodule : psram_sva

// [verification/pipelined_sync_sram_test.sv]
// self-checking test of the controller and memory pair
`timescale 1ns/1ps
module pipelined_sync_sram_test
  import psram_pkg::*;
;
  logic clk_sys, rst_n, req_valid, req_ready, req_write, sleep_req, sleeping, rd_valid, asleep;
  logic [16:0] req_addr;
  logic [3:0] req_lanes;
  logic [35:0] req_wdata, rd_data, exp;
  int err_total, total_checks;
  int wait_n;
  psram_if bus_if ();
  psram_mem i_psram_mem (.clk_sys(clk_sys), .bus(bus_if), .asleep(asleep));
  psram_ctl i_psram_ctl (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_lanes(req_lanes),
    .req_wdata(req_wdata), .sleep_req(sleep_req), .sleeping(sleeping), .rd_valid(rd_valid),
    .rd_data(rd_data));
  psram_sva i_psram_sva (.clk_sys(clk_sys), .rst_n(rst_n), .select_n(bus_if.select_n),
    .global_write_n(bus_if.global_write_n), .sleep_request(bus_if.sleep_request),
    .protocol_strap_pins(bus_if.protocol_strap_pins), .ctl_data_oe(bus_if.ctl_data_oe),
    .mem_data_oe(bus_if.mem_data_oe));
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %0s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wait_hi(ref logic sig, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b1)
    begin
      @(negedge clk_sys);
      n++;
      if (n > lim)
      begin
        err_total++;
        $display("wrong value wait expected 1 seen %b", sig);
        summarize();
      end
    end
    wait_n = n;
  endtask : wait_hi
  task automatic access(input logic w, input logic [16:0] a, input logic [3:0] l,
    input logic [35:0] d);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_lanes = l;
    req_wdata = d;
    #1;
    wait_hi(req_ready, 300);
    @(negedge clk_sys);
    req_valid = 1'b0;
    @(negedge clk_sys);
  endtask : access
  task automatic rd(input string what, input logic [16:0] a, input logic [35:0] e);
    access(1'b0, a, 4'h0, 36'h0_0000_0000);
    wait_hi(rd_valid, 8);
    chk(what, e, rd_data);
  endtask : rd
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 17'h0_0000;
    req_lanes = 4'h0;
    req_wdata = 36'h0_0000_0000;
    sleep_req = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    wait_hi(req_ready, 300);
    chk("powerup", 36'(PSRAM_POWERUP_CYC), 36'(wait_n));
    $display("test powerup done");
    access(1'b1, 17'h1_FFFF, 4'hF, 36'hA_5A5A_5A5A);
    rd("word", 17'h1_FFFF, 36'hA_5A5A_5A5A);
    $display("test word done");
    access(1'b1, 17'h0_0010, 4'hF, 36'h0_0000_0000);
    exp = 36'h0_0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      access(1'b1, 17'h0_0010, 4'(4'h1 << i), 36'hF_FFFF_FFFF);
      exp = exp | (36'h0_0000_01FF << (9 * i));
      rd("lane", 17'h0_0010, exp);
    end
    access(1'b1, 17'h0_0010, 4'h5, 36'h0_0000_0000);
    rd("lanes", 17'h0_0010, 36'hF_F803_FE00);
    $display("test lanes done");
    access(1'b1, 17'h0_0010, 4'h0, 36'h1_2345_6789);
    rd("abort", 17'h0_0010, 36'hF_F803_FE00);
    $display("test abort done");
    sleep_req = 1'b1;
    wait_hi(sleeping, 50);
    chk("asleep", 36'h0_0000_0001, 36'(asleep));
    chk("mem_oe", 36'h0_0000_0000, 36'(bus_if.mem_data_oe));
    sleep_req = 1'b0;
    wait_hi(req_ready, 300);
    // one edge leaves sleep, then the recovery count runs
    chk("recover", 36'(PSRAM_RECOVER_CYC + 1), 36'(wait_n));
    rd("retain", 17'h1_FFFF, 36'hA_5A5A_5A5A);
    $display("test sleep done");
    summarize();
  end
endmodule : pipelined_sync_sram_test
